// *** src/bplc_top.sv ***
// general control bits 22:10 of the bridge and their effects
// assumes config writes/reads come from the bridge's config space logic on CLOCK;
// STICKY_RST_N is the aux-power reset, RST_N covers fundamental/global/power-on reset
`timescale 1ns/10ps
`include "bplc_defs.svh"

// Functional notes
// - Override code 000 ignores a low slot power limit and is the reset value.
// - Code 001 with insufficient power asserts the power override pin.
// - Code 010 with insufficient power stops only the secondary clocks set in the mask.
// - Code 011 with insufficient power stops masked clocks and asserts the pin.
// - Code 100 with insufficient power answers unsupported request except config and slot limit messages.
// - With prefetch-off clear, plain, line and multiple reads are all prefetchable.
// - With prefetch-off set, only line and multiple reads prefetch, plain reads never.
// - The standby exit latency field appears as capability bits 8:6.
// - Standby latency codes double from under 64 ns up to over 4 us, reset 000.
// - The sleep exit latency field appears as capability bits 11:9.
// - Sleep latency codes double from under 1 us up to over 64 us, reset 000.
// - The virtual channel capability bit is read-only zero.
// - With d3 clock stop set, secondary clocks stop in D3, else they run.
// - Wake from L2 uses WAKE only when beacon enable is clear, beacon and WAKE when set.
// - Non-sticky fields reset on fundamental, global or power-on reset.
// - The d3 clock stop and beacon enable bits are sticky across aux power.
module bplc_top
  import bplc_pkg::*;
#(
  parameter int NCLK = `BPLC_NCLK
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic STICKY_RST_N,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  input wire logic POWER_SHORT,
  input wire logic [NCLK-1:0] CLOCK_MASK,
  input wire logic IN_D3,
  input wire logic WAKE_REQ,
  input wire logic REQ_VALID,
  input wire logic REQ_IS_CFG,
  input wire logic REQ_IS_SLOT_LIMIT,
  input wire logic [1:0] RD_KIND,
  output logic POWER_OVERRIDE_PIN,
  output logic [NCLK-1:0] SEC_CLK_EN,
  output logic REQ_UNSUPPORTED,
  output logic RD_PREFETCH,
  output logic [11:0] DEVCAP_LAT,
  output logic WAKE_OUT,
  output logic BEACON_OUT
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  bplc_ctrl_t ctrl;
  logic [2:0] resp_sel;
  logic pf_off;
  logic [2:0] standby_lat;
  logic [2:0] sleep_lat;
  logic d3_stop_on;
  logic beacon_on;
  logic short_s1;
  logic short_s2;

  wire hit = (CFG_ADDR == `BPLC_GC_OFFSET);
  wire wr_b2 = CFG_WR & hit & CFG_BE[2];
  wire wr_b1 = CFG_WR & hit & CFG_BE[1];

  // bank image has one driver; main and sticky bits live in separate flops
  assign ctrl = {resp_sel, pf_off, standby_lat, sleep_lat, d3_stop_on, beacon_on};

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      resp_sel <= `BPLC_OVRD_IGNORE;
      pf_off <= 1'b0;
      standby_lat <= `BPLC_LAT_RESET;
      sleep_lat <= `BPLC_LAT_RESET;
    end else begin
      if (wr_b2) begin
        resp_sel <= CFG_WDATA[`BPLC_OVRD_HI:`BPLC_OVRD_LO];
        pf_off <= CFG_WDATA[`BPLC_PFOFF_BIT];
        standby_lat <= CFG_WDATA[`BPLC_L0S_HI:`BPLC_L0S_LO];
      end
      if (wr_b1) begin
        sleep_lat <= CFG_WDATA[`BPLC_L1_HI:`BPLC_L1_LO];
      end
    end
  end

  // sticky bits survive the main reset
  always_ff @(posedge CLOCK or negedge STICKY_RST_N) begin
    if (!STICKY_RST_N) begin
      d3_stop_on <= 1'b0;
      beacon_on <= 1'b0;
    end else if (wr_b1) begin
      d3_stop_on <= CFG_WDATA[`BPLC_D3STOP_BIT];
      beacon_on <= CFG_WDATA[`BPLC_BEACON_BIT];
    end
  end

  // ------------------------------------------------------------
  // power shortfall sync
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      short_s1 <= 1'b0;
      short_s2 <= 1'b0;
    end else begin
      short_s1 <= POWER_SHORT;
      short_s2 <= short_s1;
    end
  end

  // ------------------------------------------------------------
  // decode of effects
  // ------------------------------------------------------------
  wire [2:0] sel = ctrl.slot_power_response_select;
  wire want_pin = (sel == `BPLC_OVRD_PIN) | (sel == `BPLC_OVRD_CLK_PIN);
  wire want_clk = (sel == `BPLC_OVRD_CLK) | (sel == `BPLC_OVRD_CLK_PIN);
  wire want_ur = (sel == `BPLC_OVRD_UR);
  wire [NCLK-1:0] mask_stop = (short_s2 & want_clk) ? CLOCK_MASK : '0;
  wire [NCLK-1:0] d3_stop = {NCLK{IN_D3 & ctrl.d3_secondary_clock_stop}};
  wire next_ur = REQ_VALID & short_s2 & want_ur & ~REQ_IS_CFG & ~REQ_IS_SLOT_LIMIT;
  wire next_pf = (RD_KIND == BPLC_RD_LINE) | (RD_KIND == BPLC_RD_MULTIPLE) |
                 ((RD_KIND == BPLC_RD_PLAIN) & ~ctrl.plain_read_prefetch_off);

  wire [31:0] next_rdata = hit ? {9'h000,
                                  ctrl.slot_power_response_select,
                                  ctrl.plain_read_prefetch_off,
                                  ctrl.standby_exit_latency,
                                  ctrl.sleep_exit_latency,
                                  1'b0,
                                  ctrl.d3_secondary_clock_stop,
                                  ctrl.beacon_enable,
                                  10'h000} : 32'h0000_0000;

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_RDATA <= 32'h0000_0000;
      POWER_OVERRIDE_PIN <= 1'b0;
      SEC_CLK_EN <= '1;
      REQ_UNSUPPORTED <= 1'b0;
      RD_PREFETCH <= 1'b0;
      DEVCAP_LAT <= 12'h000;
      WAKE_OUT <= 1'b0;
      BEACON_OUT <= 1'b0;
    end else begin
      if (CFG_RD) begin
        CFG_RDATA <= next_rdata;
      end
      POWER_OVERRIDE_PIN <= short_s2 & want_pin;
      SEC_CLK_EN <= ~(mask_stop | d3_stop);
      REQ_UNSUPPORTED <= next_ur;
      RD_PREFETCH <= next_pf;
      DEVCAP_LAT <= {ctrl.sleep_exit_latency, ctrl.standby_exit_latency, 6'h00};
      WAKE_OUT <= WAKE_REQ;
      BEACON_OUT <= WAKE_REQ & ctrl.beacon_enable;
    end
  end

endmodule

// *** src/bplc_defs.svh ***
// constants for the bridge power/link control bank
// assumes inclusion by bare name from package and module
`ifndef BPLC_DEFS_SVH
`define BPLC_DEFS_SVH
`define BPLC_GC_OFFSET 8'hD4
`define BPLC_OVRD_HI 22
`define BPLC_OVRD_LO 20
`define BPLC_PFOFF_BIT 19
`define BPLC_L0S_HI 18
`define BPLC_L0S_LO 16
`define BPLC_L1_HI 15
`define BPLC_L1_LO 13
`define BPLC_VC_BIT 12
`define BPLC_D3STOP_BIT 11
`define BPLC_BEACON_BIT 10
`define BPLC_OVRD_IGNORE 3'h0
`define BPLC_OVRD_PIN 3'h1
`define BPLC_OVRD_CLK 3'h2
`define BPLC_OVRD_CLK_PIN 3'h3
`define BPLC_OVRD_UR 3'h4
`define BPLC_LAT_RESET 3'h0
`define BPLC_NCLK 7
`endif

// *** src/bplc_pkg.sv ***
// types for the bridge power/link control bank
// assumes bplc_defs.svh on the include path
`include "bplc_defs.svh"
package bplc_pkg;
  typedef struct packed {
    logic [2:0] slot_power_response_select;
    logic plain_read_prefetch_off;
    logic [2:0] standby_exit_latency;
    logic [2:0] sleep_exit_latency;
    logic d3_secondary_clock_stop;
    logic beacon_enable;
  } bplc_ctrl_t;
  typedef enum logic [1:0] {
    BPLC_RD_PLAIN,
    BPLC_RD_LINE,
    BPLC_RD_MULTIPLE,
    BPLC_RD_OTHER
  } bplc_rd_t;
endpackage

// *** dv/bplc_sva.sv ***
// port checker for bplc_top
// assumes binding onto bplc_top
`timescale 1ns/10ps
module bplc_sva
  import bplc_pkg::*;
#(
  parameter int NCLK = 7
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [31:0] CFG_RDATA,
  input wire logic POWER_SHORT,
  input wire logic IN_D3,
  input wire logic WAKE_REQ,
  input wire logic REQ_VALID,
  input wire logic REQ_IS_CFG,
  input wire logic REQ_IS_SLOT_LIMIT,
  input wire logic [1:0] RD_KIND,
  input wire logic POWER_OVERRIDE_PIN,
  input wire logic [NCLK-1:0] SEC_CLK_EN,
  input wire logic REQ_UNSUPPORTED,
  input wire logic RD_PREFETCH,
  input wire logic [11:0] DEVCAP_LAT,
  input wire logic WAKE_OUT,
  input wire logic BEACON_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  AST_RSVD: assert property (CFG_RD |=> !CFG_RDATA[12] && CFG_RDATA[31:23] == 9'h0)
    else $error("reserved bits set");
  AST_LAT: assert property (CFG_RD && !CFG_WR && CFG_ADDR == 8'hD4 |=>
    DEVCAP_LAT == {CFG_RDATA[15:13], CFG_RDATA[18:16], 6'h00}) else $error("latency image");
  AST_PF: assert property (RD_KIND == 2'h1 || RD_KIND == 2'h2 |=> RD_PREFETCH)
    else $error("line read not prefetched");
  AST_NOPIN: assert property (!POWER_SHORT [*4] |-> !POWER_OVERRIDE_PIN)
    else $error("pin without short");
  AST_CLK: assert property ((!POWER_SHORT && !IN_D3) [*4] |-> &SEC_CLK_EN)
    else $error("clock stopped");
  AST_UR: assert property (!REQ_VALID || REQ_IS_CFG || REQ_IS_SLOT_LIMIT |=> !REQ_UNSUPPORTED)
    else $error("bad unsupported");
  AST_WAKE: assert property (WAKE_REQ |=> WAKE_OUT)
    else $error("no wake");
  AST_BEACON: assert property (BEACON_OUT |-> WAKE_OUT)
    else $error("beacon alone");
  AST_RST: assert property ($rose(RST_N) |-> !POWER_OVERRIDE_PIN && DEVCAP_LAT == 12'h000)
    else $error("not reset");
endmodule
bind bplc_top bplc_sva #(.NCLK(NCLK)) u_sva (.*);

// *** dv/bplc_top_tb.sv ***
// self-checking bench for bplc_top
// assumes bplc_pkg and bplc_sva compiled first
`timescale 1ns/10ps
module bplc_top_tb;
  import bplc_pkg::*;
  logic CLOCK = 0, RST_N = 0, STICKY_RST_N = 0, CFG_WR = 0, CFG_RD = 0;
  logic POWER_SHORT = 0, IN_D3 = 0, WAKE_REQ = 0, REQ_VALID = 0, REQ_IS_CFG = 0;
  logic POWER_OVERRIDE_PIN, REQ_UNSUPPORTED, RD_PREFETCH, WAKE_OUT, BEACON_OUT;
  logic [7:0] CFG_ADDR = 8'hD4;
  logic [3:0] CFG_BE = 4'h6;
  logic REQ_IS_SLOT_LIMIT = 0;
  logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA;
  logic [1:0] RD_KIND = 2'h0;
  logic [6:0] CLOCK_MASK = 7'h55, SEC_CLK_EN;
  logic [11:0] DEVCAP_LAT;
  logic [63:0] rows [4] = '{64'hFFFFFFFF_007FEC00, 64'h00310C00_00310C00,
    64'h0055A400_0055A400, 64'h0};
  int n_mismatch = 0, tests_run = 0;
  bplc_top uut (.*);
  initial forever #2.5 CLOCK = ~CLOCK;
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [31:0] d);
    @(negedge CLOCK);
    CFG_WR = 1;
    CFG_WDATA = d;
    @(negedge CLOCK);
    CFG_WR = 0;
  endtask
  task automatic rd(logic [31:0] exp);
    @(negedge CLOCK);
    CFG_RD = 1;
    @(negedge CLOCK);
    CFG_RD = 0;
    chk("rdata", CFG_RDATA, exp);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge CLOCK);
    RST_N = 1;
    STICKY_RST_N = 1;
    rd(32'h0);
    foreach (rows[i]) begin
      wr(rows[i][63:32]);
      rd(rows[i][31:0]);
      chk("devcap", DEVCAP_LAT, {rows[i][15:13], rows[i][18:16], 6'h00});
    end
    for (int p = 0; p < 2; p++) begin
      wr({12'h0, p[0], 19'h0});
      for (int k = 0; k < 4; k++) begin
        RD_KIND = k[1:0];
        @(negedge CLOCK);
        chk("prefetch", RD_PREFETCH, k == 1 || k == 2 || (k == 0 && p == 0));
      end
    end
    POWER_SHORT = 1;
    REQ_VALID = 1;
    for (int c = 0; c < 8; c++) begin
      wr({9'h0, c[2:0], 20'h0});
      repeat (4) @(negedge CLOCK);
      chk("pin", POWER_OVERRIDE_PIN, c == 1 || c == 3);
      chk("clken", SEC_CLK_EN, c == 2 || c == 3 ? 7'h2A : 7'h7F);
      chk("ur", REQ_UNSUPPORTED, c == 4);
      REQ_IS_CFG = 1;
      @(negedge CLOCK);
      chk("ur cfg", REQ_UNSUPPORTED, 0);
      REQ_IS_CFG = 0;
      REQ_IS_SLOT_LIMIT = 1;
      @(negedge CLOCK);
      chk("ur slot", REQ_UNSUPPORTED, 0);
      REQ_IS_SLOT_LIMIT = 0;
    end
    POWER_SHORT = 0;
    REQ_VALID = 0;
    wr(32'h00314C00);
    IN_D3 = 1;
    WAKE_REQ = 1;
    repeat (4) @(negedge CLOCK);
    chk("d3 stop", SEC_CLK_EN, 0);
    chk("beacon", {WAKE_OUT, BEACON_OUT}, 2'b11);
    RST_N = 0;
    @(negedge CLOCK);
    RST_N = 1;
    rd(32'h00000C00);
    STICKY_RST_N = 0;
    @(negedge CLOCK);
    STICKY_RST_N = 1;
    rd(32'h0);
    repeat (3) @(negedge CLOCK);
    chk("d3 run", SEC_CLK_EN, 7'h7F);
    chk("wake only", {WAKE_OUT, BEACON_OUT}, 2'b10);
    CFG_BE = 4'h4;
    wr(32'hFFFFFFFF);
    rd(32'h007F0000);
    CFG_BE = 4'h2;
    wr(32'hFFFFFFFF);
    rd(32'h007FEC00);
    CFG_BE = 4'h6;
    CFG_ADDR = 8'hD8;
    wr(32'h0);
    rd(32'h0);
    CFG_ADDR = 8'hD4;
    rd(32'h007FEC00);
    report_and_stop;
  end
endmodule
